/* hdl/pir_engine_pkg.sv */
// Purpose: constants for the motion engine status/control block
// Assumes: 100 MHz clock, APB with 32-bit data
// Notes:   register byte address is four times the register index
package pir_engine_pkg;
    localparam int         ADDR_W        = 12;
    localparam int         SAMPLE_W      = 10;
    localparam int         CH            = 2;
    // register indices and byte addresses
    localparam int         IDX_ENABLE    = 'h100;
    localparam int         IDX_SC0       = 'h102;
    localparam int         IDX_SC1       = 'h103;
    localparam int         IDX_CONV      = 'h10D;
    localparam logic [11:0] ADDR_ENABLE  = 12'(IDX_ENABLE * 4);
    localparam logic [11:0] ADDR_SC0     = 12'(IDX_SC0 * 4);
    localparam logic [11:0] ADDR_SC1     = 12'(IDX_SC1 * 4);
    localparam logic [11:0] ADDR_CONV    = 12'(IDX_CONV * 4);
    // engine enable codes
    localparam logic [7:0] ENGINE_ON_CODE  = 8'h11;
    localparam logic [7:0] ENGINE_OFF_CODE = 8'h00;
    // field positions
    localparam int         SC0_LEVEL_LSB = 6;
    localparam int         SC0_OFF       = 5;
    localparam int         SC0_HOLD      = 4;
    localparam int         SC0_DIRM      = 3;
    localparam int         SC0_DIR       = 2;
    localparam int         SC0_MOTION    = 1;
    localparam int         SC0_STABLE    = 0;
    localparam int         SC1_TICK      = 7;
    localparam int         SC1_FR_LSB    = 3;
    localparam int         SC1_SCAN      = 2;
    localparam int         SC1_DUAL      = 0;
    localparam int         CONV_START    = 7;
    localparam logic [3:0] FR_MAX        = 4'hC;
    localparam logic [7:0] ENABLE_RST    = 8'h00;
    // timing
    localparam int         CLK_MHZ          = 100;
    localparam int         NORMAL_CONV_CLKS = 256;
    localparam int         LOW_CONV_CLKS    = 5129;
    localparam int         RATE_HOLD_MS     = 200;
    localparam int         RATE_HOLD_CLKS   = RATE_HOLD_MS * CLK_MHZ * 1000;
    // detector tuning
    localparam logic [9:0] DET_THR_BASE   = 10'h040;
    localparam logic [9:0] QUIET_THR      = 10'h004;
    localparam logic [6:0] STABLE_SAMPLES = 7'h40;
    localparam logic [3:0] SHIFT_BASE     = 4'h2;
endpackage : pir_engine_pkg

/* hdl/pir_engine_status_control.sv */
// Purpose: motion engine with its status/control registers over APB
// Assumes: samples arrive on pins from an external converter front end
// Notes:   one wait state on every APB access
// Functional notes
// - level field 0 least, 3 most sensitive
// - enable code clears engine-disabled flag
// - disable code sets flag, processing stops
// - suspend blocks detection, baseline keeps tracking
// - suspend ends at next conversion
// - direction mode bit selects directional reporting
// - direction written when motion flag sets
// - direction holds until motion flag cleared
// - motion flag sticky until software writes zero
// - stable flag set after offset settles
// - no motion events while not stable
// - engine consumes and clears tick bit
// - frequency response 0 to 12 sets cutoff
// - normal rate converts every 256 clocks
// - low rate single shot, 5129 clocks
// - low rate powers converter down, no immunity
// - scan rate change suppresses detection 200 ms
// - dual bit adds second sensor input
// - only on and off codes change the flag; any other code also stops processing
`timescale 1ns/1ps
module pir_engine_status_control
    import pir_engine_pkg::*;
#(
    parameter int RATE_HOLD_CYCLES = RATE_HOLD_CLKS,
    parameter int LOW_CONV_CYCLES  = LOW_CONV_CLKS
) (
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [SAMPLE_W-1:0] sensor_a_sample,
    input  wire logic [SAMPLE_W-1:0] sensor_b_sample,
    output logic                     converter_power,
    output logic                     emi_immunity
);
    logic [7:0]          enable_code_r;
    logic [1:0]          level_r;
    logic [3:0]          fr_r, shift;
    logic [12:0]         conv_cnt_r;
    logic [24:0]         hold_cnt_r;
    logic [6:0]          quiet_cnt_r;
    logic [31:0]         prdata_r, rd_word;
    logic [9:0]          det_thr;
    logic [SAMPLE_W-1:0] raw [CH];
    logic [CH-1:0]       hit, pos, quiet, act;
    logic                off_r, hold_bit_r, hold_act_r, dirm_r, dir_r, motion_r, stable_r;
    logic                tick_r, scan_r, scan_prev_r, dual_r, start_r, conv_busy_r;
    logic                sec_seen_r, pready_r, pslverr_r, converter_power_r, emi_immunity_r;
    logic                conv_done, mapped, wr_acc, wr_en, wr_sc0, wr_sc1, wr_conv, on_wr;
    logic                eng_evt, detect, sw_tick_set, motion_set, any_hit, dir_now;

    assign raw[0] = sensor_a_sample;
    assign raw[1] = sensor_b_sample;
    // apb slave, one wait state
    assign wr_acc  = psel & penable & pwrite & pready_r;
    assign wr_en   = wr_acc & (paddr == ADDR_ENABLE);
    assign wr_sc0  = wr_acc & (paddr == ADDR_SC0);
    assign wr_sc1  = wr_acc & (paddr == ADDR_SC1);
    assign wr_conv = wr_acc & (paddr == ADDR_CONV);
    assign on_wr   = wr_en & (pwdata[7:0] == ENGINE_ON_CODE);
    assign mapped  = (paddr == ADDR_ENABLE) | (paddr == ADDR_SC0) |
                     (paddr == ADDR_SC1) | (paddr == ADDR_CONV);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            ADDR_ENABLE: rd_word[7:0] = enable_code_r;
            ADDR_SC0:    rd_word[7:0] = {level_r, off_r, hold_bit_r, dirm_r,
                                         dir_r, motion_r, stable_r};
            ADDR_SC1:    rd_word[7:0] = {tick_r, fr_r, scan_r, 1'b0, dual_r};
            ADDR_CONV:   rd_word[CONV_START] = start_r;
            default:     rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~mapped;
            if (psel & penable & ~pready_r & ~pwrite) begin
                prdata_r <= rd_word;
            end
        end
    end

    // application-controlled fields
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_code_r <= ENABLE_RST;
            level_r       <= 2'b00;
            hold_bit_r    <= 1'b0;
            dirm_r        <= 1'b0;
            fr_r          <= 4'h0;
            scan_r        <= 1'b0;
            dual_r        <= 1'b0;
        end else begin
            if (wr_en) begin
                enable_code_r <= pwdata[7:0];
            end
            if (wr_sc0) begin
                level_r    <= pwdata[SC0_LEVEL_LSB+:2];
                hold_bit_r <= pwdata[SC0_HOLD];
                dirm_r     <= pwdata[SC0_DIRM];
            end
            if (wr_sc1) begin
                fr_r   <= (pwdata[SC1_FR_LSB+:4] > FR_MAX) ? FR_MAX
                                                           : pwdata[SC1_FR_LSB+:4];
                scan_r <= pwdata[SC1_SCAN];
                dual_r <= pwdata[SC1_DUAL];
            end
        end
    end

    // engine on/off state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            off_r <= 1'b1;
        end else if (on_wr) begin
            off_r <= 1'b0;
        end else if (conv_done & (enable_code_r == ENGINE_OFF_CODE)) begin
            off_r <= 1'b1;
        end
    end

    a_off_after_conv: assert property (@(posedge clk) disable iff (!reset_n)
        conv_done & (enable_code_r == ENGINE_OFF_CODE) & !on_wr |=> off_r)
        else $error("disable code not acknowledged");
    a_on_clears_off: assert property (@(posedge clk) disable iff (!reset_n)
        on_wr |=> !off_r && !stable_r && !motion_r)
        else $error("enable code did not clear disabled flag");

    assign eng_evt = conv_done & ~off_r & (enable_code_r == ENGINE_ON_CODE);
    // converter sequencing
    assign conv_done = conv_busy_r &
        (scan_r ? (conv_cnt_r == 13'(LOW_CONV_CYCLES - 1))
                : (conv_cnt_r == 13'(NORMAL_CONV_CLKS - 1)));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_cnt_r  <= 13'h0000;
            conv_busy_r <= 1'b0;
        end else if (off_r | (scan_r != scan_prev_r)) begin
            conv_cnt_r  <= 13'h0000;
            conv_busy_r <= ~off_r & ~scan_r;
        end else if (conv_done) begin
            conv_cnt_r  <= 13'h0000;
            conv_busy_r <= ~scan_r;
        end else if (conv_busy_r) begin
            conv_cnt_r  <= conv_cnt_r + 13'h0001;
        end else if (~scan_r | start_r) begin
            // normal rate restarts on its own, low rate waits for start
            conv_busy_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            start_r <= 1'b0;
        end else if (wr_conv & pwdata[CONV_START]) begin
            start_r <= 1'b1;
        end else if (conv_done | ~scan_r) begin
            start_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            converter_power_r <= 1'b0;
            emi_immunity_r    <= 1'b0;
        end else begin
            converter_power_r <= ~off_r & (~scan_r | conv_busy_r);
            emi_immunity_r    <= ~scan_r;
        end
    end

    a_low_power_down: assert property (@(posedge clk) disable iff (!reset_n)
        scan_r & !conv_busy_r & $past(scan_r & !conv_busy_r) |-> !converter_power_r)
        else $error("converter powered between low rate conversions");
    a_normal_period: assert property (@(posedge clk) disable iff (!reset_n)
        conv_done & !scan_r |-> ##256 (conv_done | scan_r | off_r))
        else $error("normal conversion period not kept");

    // scan rate change suppression
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scan_prev_r <= 1'b0;
            hold_cnt_r  <= 25'h000_0000;
        end else begin
            scan_prev_r <= scan_r;
            if ((scan_r != scan_prev_r) & ~off_r) begin
                hold_cnt_r <= 25'(RATE_HOLD_CYCLES);
            end else if (hold_cnt_r != 25'h000_0000) begin
                hold_cnt_r <= hold_cnt_r - 25'h000_0001;
            end
        end
    end
    // suspend takes effect at conversion boundaries
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_act_r <= 1'b0;
        end else if (conv_done) begin
            hold_act_r <= hold_bit_r;
        end
    end

    assign det_thr = DET_THR_BASE >> level_r;
    assign shift   = SHIFT_BASE + {1'b0, fr_r[3:1]};
    assign act     = {dual_r, 1'b1};

    // per-sensor sync, baseline tracker and detector
    for (genvar ch = 0; ch < CH; ch++) begin : g_ch
        logic [SAMPLE_W-1:0] s1_r;
        logic [SAMPLE_W-1:0] s2_r;
        logic [17:0]         base_r;
        logic                prev_hit_r;
        logic signed [18:0]  diff;
        logic signed [18:0]  step;
        logic signed [10:0]  dev;
        logic [9:0]          mag;
        logic                raw_hit;

        assign diff    = $signed({1'b0, s2_r, 8'h00}) - $signed({1'b0, base_r});
        assign step    = diff >>> shift;
        assign dev     = $signed({1'b0, s2_r}) - $signed({1'b0, base_r[17:8]});
        assign mag     = dev[10] ? 10'(-dev) : dev[9:0];
        assign raw_hit = mag > det_thr;
        assign hit[ch]   = raw_hit & (~emi_immunity_r | prev_hit_r);
        assign pos[ch]   = ~dev[10];
        assign quiet[ch] = mag < QUIET_THR;

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                s1_r <= '0;
                s2_r <= '0;
            end else begin
                s1_r <= raw[ch];
                s2_r <= s1_r;
            end
        end

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                base_r     <= 18'h0_0000;
                prev_hit_r <= 1'b0;
            end else if (on_wr) begin
                base_r     <= {s2_r, 8'h00};
                prev_hit_r <= 1'b0;
            end else if (eng_evt) begin
                base_r     <= base_r + step[17:0];
                prev_hit_r <= raw_hit;
            end
        end
    end

    // stability tracking
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quiet_cnt_r <= 7'h00;
            stable_r    <= 1'b0;
        end else if (on_wr) begin
            quiet_cnt_r <= 7'h00;
            stable_r    <= 1'b0;
        end else if (eng_evt) begin
            if (&(quiet | ~act)) begin
                if (quiet_cnt_r != STABLE_SAMPLES) begin
                    quiet_cnt_r <= quiet_cnt_r + 7'h01;
                end
            end else if (!stable_r) begin
                quiet_cnt_r <= 7'h00;
            end
            if ((quiet_cnt_r == STABLE_SAMPLES) & sec_seen_r) begin
                stable_r <= 1'b1;
            end
        end
    end
    // one second tick
    assign sw_tick_set = wr_sc1 & pwdata[SC1_TICK];
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_r <= 1'b0;
        end else if (sw_tick_set) begin
            tick_r <= 1'b1;
        end else if (eng_evt) begin
            tick_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sec_seen_r <= 1'b0;
        end else if (on_wr) begin
            sec_seen_r <= 1'b0;
        end else if (eng_evt & tick_r) begin
            sec_seen_r <= 1'b1;
        end
    end
    a_tick_consumed: assert property (@(posedge clk) disable iff (!reset_n)
        eng_evt & tick_r & !sw_tick_set |=> !tick_r)
        else $error("tick not cleared by engine");

    // motion detection and direction
    assign any_hit    = |(hit & act);
    assign dir_now    = hit[0] ? pos[0] : pos[1];
    assign detect     = eng_evt & ~hold_act_r & stable_r & (hold_cnt_r == 25'h000_0000);
    assign motion_set = detect & any_hit;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            motion_r <= 1'b0;
        end else if (on_wr | (wr_sc0 & ~pwdata[SC0_MOTION] & ~motion_set)) begin
            motion_r <= 1'b0;
        end else if (motion_set) begin
            motion_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dir_r <= 1'b0;
        end else if (on_wr) begin
            dir_r <= 1'b0;
        end else if (motion_set & ~motion_r & dirm_r) begin
            dir_r <= dir_now;
        end
    end

    a_motion_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        motion_r & !on_wr & !(wr_sc0 & !pwdata[SC0_MOTION]) |=> motion_r)
        else $error("motion flag dropped without clear");
    a_motion_stable: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(motion_r) |-> $past(stable_r) && !$past(hold_act_r))
        else $error("motion flagged while unstable or suspended");
    a_rate_hold: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(motion_r) |-> $past(hold_cnt_r) == 25'h000_0000)
        else $error("motion flagged during scan rate hold");
    a_dir_latched: assert property (@(posedge clk) disable iff (!reset_n)
        motion_r & $past(motion_r) & !$past(on_wr) |-> $stable(dir_r))
        else $error("direction changed while motion latched");
    a_fr_legal: assert property (@(posedge clk) disable iff (!reset_n)
        fr_r <= FR_MAX)
        else $error("frequency response out of range");

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign converter_power = converter_power_r;
    assign emi_immunity    = emi_immunity_r;
endmodule : pir_engine_status_control

/* tb/pyro_sensor_model.sv */
// Purpose: pyroelectric sensor pair behind a converter, as the engine sees it
// Assumes: the bench sets a signed offset per channel around an idle level
// Notes:   a one-count ripple keeps the idle signal from being perfectly flat
`timescale 1ns/1ps
module pyro_sensor_model
    import pir_engine_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic signed [10:0]  offset_a,
    input  wire logic signed [10:0]  offset_b,
    output logic      [SAMPLE_W-1:0] sample_a,
    output logic      [SAMPLE_W-1:0] sample_b
);
    localparam logic signed [10:0] IDLE_LEVEL = 11'sh200;
    logic                          ripple_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ripple_r <= 1'b0;
        end else begin
            ripple_r <= ~ripple_r;
        end
    end

    // channels ripple in opposite senses so neither is a copy of the other
    always_comb begin
        sample_a = SAMPLE_W'(IDLE_LEVEL + offset_a + 11'(ripple_r));
        sample_b = SAMPLE_W'(IDLE_LEVEL + offset_b - 11'(ripple_r));
    end
endmodule : pyro_sensor_model

/* tb/tb.sv */
// Purpose: register-level bench for the motion engine status/control block
// Assumes: short rate hold and low-rate conversion parameters
// Notes:   motion is made by offsetting the sensor model for a few conversions
`timescale 1ns/1ps
module tb import pir_engine_pkg::*; ;
    localparam int      CONV = NORMAL_CONV_CLKS;
    logic               clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic               conv_power, emi_on, err;
    logic signed [10:0] off_a, off_b;
    logic [9:0]         samp_a, samp_b;
    int                 miscompares, n_compared, cycles;

    pir_engine_status_control #(.RATE_HOLD_CYCLES(50), .LOW_CONV_CYCLES(20))
        pir_engine_status_control_i (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sensor_a_sample(samp_a),
        .sensor_b_sample(samp_b), .converter_power(conv_power), .emi_immunity(emi_on)
    );

    pyro_sensor_model pyro_sensor_model_i (
        .clk(clk), .reset_n(reset_n), .offset_a(off_a), .offset_b(off_b),
        .sample_a(samp_a), .sample_b(samp_b)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 100_000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n       = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk("wait states", n, 32'h0000_0002);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr

    // bits above the byte are always expected to read zero
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] m,
                          input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd & {24'hff_ffff, m}, {24'h0, e});
    endtask : rd_chk

    task automatic pins(input logic pwr, input logic emi);
        repeat (3) @(negedge clk);
        chk("converter power", {31'h0, conv_power}, {31'h0, pwr});
        chk("emi immunity", {31'h0, emi_on}, {31'h0, emi});
        @(posedge clk);
    endtask : pins

    // hold an offset for six conversions, then let the baseline settle
    task automatic pulse(input logic signed [10:0] amt, input logic on_b);
        if (on_b) begin
            off_b <= amt;
        end else begin
            off_a <= amt;
        end
        repeat (6 * CONV) @(posedge clk);
        off_a <= '0;
        off_b <= '0;
        repeat (16 * CONV) @(posedge clk);
    endtask : pulse

    initial begin
        int n;
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {off_a, off_b, miscompares, n_compared, cycles, n} = '0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd_chk("enable code", ADDR_ENABLE, 8'hff, 8'h00);
        rd_chk("disabled flag", ADDR_SC0, 8'h20, 8'h20);
        apb(1'b0, 12'h7f0, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        wr(ADDR_SC0, 8'hff);
        rd_chk("status0 access", ADDR_SC0, 8'hfb, 8'hf8);
        wr(ADDR_SC1, 8'h7b);
        rd_chk("status1 clamp", ADDR_SC1, 8'hff, 8'h61);
        wr(ADDR_SC1, 8'h00);
        wr(ADDR_SC0, 8'h00);
        wr(ADDR_ENABLE, ENGINE_ON_CODE);
        rd_chk("disabled clear", ADDR_SC0, 8'h20, 8'h00);
        pins(1'b1, 1'b1);
        pulse(11'sd200, 1'b0);
        rd_chk("motion unstable", ADDR_SC0, 8'h02, 8'h00);
        wr(ADDR_SC1, 8'h80);
        repeat (2 * CONV) @(posedge clk);
        rd_chk("tick cleared", ADDR_SC1, 8'h80, 8'h00);
        do begin
            repeat (64) @(posedge clk);
            apb(1'b0, ADDR_SC0, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 400);
        rd_chk("stable", ADDR_SC0, 8'h01, 8'h01);
        pulse(11'sd20, 1'b0);
        rd_chk("level 0 small", ADDR_SC0, 8'h02, 8'h00);
        wr(ADDR_SC0, 8'hc0);
        pulse(11'sd20, 1'b0);
        rd_chk("level 3 small", ADDR_SC0, 8'h02, 8'h02);
        wr(ADDR_SC0, 8'h08);
        pulse(11'sd200, 1'b0);
        rd_chk("positive motion", ADDR_SC0, 8'h06, 8'h06);
        wr(ADDR_SC0, 8'h0a);
        pulse(-11'sd200, 1'b0);
        rd_chk("direction held", ADDR_SC0, 8'h06, 8'h06);
        wr(ADDR_SC0, 8'h08);
        rd_chk("motion cleared", ADDR_SC0, 8'h02, 8'h00);
        pulse(-11'sd200, 1'b0);
        rd_chk("negative motion", ADDR_SC0, 8'h06, 8'h02);
        wr(ADDR_SC0, 8'h10);
        pulse(11'sd200, 1'b0);
        rd_chk("suspended", ADDR_SC0, 8'h02, 8'h00);
        wr(ADDR_SC0, 8'h00);
        pulse(11'sd200, 1'b0);
        rd_chk("resumed", ADDR_SC0, 8'h02, 8'h02);
        wr(ADDR_SC0, 8'h00);
        pulse(11'sd200, 1'b1);
        rd_chk("single sensor", ADDR_SC0, 8'h02, 8'h00);
        wr(ADDR_SC1, 8'h01);
        pulse(11'sd200, 1'b1);
        rd_chk("dual sensor", ADDR_SC0, 8'h02, 8'h02);
        wr(ADDR_SC0, 8'h00);
        wr(ADDR_ENABLE, 8'h55);
        rd_chk("reserved code", ADDR_ENABLE, 8'hff, 8'h55);
        rd_chk("reserved no act", ADDR_SC0, 8'h20, 8'h00);
        wr(ADDR_ENABLE, ENGINE_OFF_CODE);
        repeat (2 * CONV) @(posedge clk);
        rd_chk("disabled set", ADDR_SC0, 8'h20, 8'h20);
        pulse(11'sd200, 1'b0);
        rd_chk("no processing", ADDR_SC0, 8'h02, 8'h00);
        wr(ADDR_ENABLE, ENGINE_ON_CODE);
        wr(ADDR_SC1, 8'h04);
        pins(1'b0, 1'b0);
        wr(ADDR_CONV, 8'h80);
        pins(1'b1, 1'b0);
        rd_chk("start busy", ADDR_CONV, 8'h80, 8'h80);
        repeat (20) @(posedge clk);
        rd_chk("start done", ADDR_CONV, 8'h80, 8'h00);
        pins(1'b0, 1'b0);
        report_and_stop();
    end
endmodule : tb
